//--- verilog/rlsr_pkg.sv
`default_nettype none
package rlsr_pkg;
  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_SWITCHING_FREQ_SETPOINT = 8'h33;
  localparam logic [7:0] CODE_INPUT_START_THRESHOLD = 8'h35;
  localparam logic [7:0] CODE_INPUT_STOP_THRESHOLD = 8'h36;
  localparam logic [7:0] CODE_CURRENT_READING_OFFSET = 8'h39;
  localparam logic [7:0] CODE_OUT_OVERVOLT_FAULT_LEVEL = 8'h40;
  localparam logic [7:0] CODE_OUT_OVERVOLT_FAULT_ACTION = 8'h41;
  localparam logic [7:0] CODE_OUT_OVERVOLT_WARN_LEVEL = 8'h42;
  localparam logic [7:0] CODE_OUT_UNDERVOLT_WARN_LEVEL = 8'h43;
  localparam logic [7:0] CODE_OUT_UNDERVOLT_FAULT_LEVEL = 8'h44;
  localparam logic [7:0] CODE_OUT_UNDERVOLT_FAULT_ACTION = 8'h45;
  localparam logic [7:0] CODE_OUT_OVERCURRENT_FAULT_ACTION = 8'h47;
  localparam logic [7:0] CODE_OUT_OVERCURRENT_WARN_LEVEL = 8'h4a;
  localparam logic [7:0] CODE_DIE_OVERTEMP_FAULT_LEVEL = 8'h4f;
  localparam logic [7:0] CODE_DIE_OVERTEMP_FAULT_ACTION = 8'h50;
  localparam logic [7:0] CODE_DIE_OVERTEMP_WARN_LEVEL = 8'h51;
  localparam logic [7:0] CODE_IN_OVERVOLT_FAULT_ACTION = 8'h56;
  localparam logic [7:0] CODE_IN_UNDERVOLT_WARN_LEVEL = 8'h58;
  localparam logic [7:0] CODE_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CODE_TURN_ON_RAMP_TIME = 8'h61;
  localparam logic [7:0] CODE_TURN_ON_TIMEOUT = 8'h62;
  localparam logic [7:0] CODE_TURN_ON_TIMEOUT_ACTION = 8'h63;
  localparam logic [7:0] CODE_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CODE_TURN_OFF_RAMP_TIME = 8'h65;
  localparam logic [7:0] CODE_TURN_OFF_DECAY_WARN_TIME = 8'h66;
  localparam logic [7:0] CODE_FAULT_SUMMARY_BYTE = 8'h78;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_SWITCHING_FREQ_SETPOINT = 16'h63d0;
  localparam logic [15:0] RST_INPUT_START_THRESHOLD = 16'h3d9a;
  localparam logic [15:0] RST_INPUT_STOP_THRESHOLD = 16'h3d66;
  localparam logic [15:0] RST_CURRENT_READING_OFFSET = 16'h2e66;
  localparam logic [15:0] RST_OUT_OVERVOLT_FAULT_LEVEL = 16'h3866;
  localparam logic [15:0] RST_OUT_OVERVOLT_FAULT_ACTION = 16'h00b8;
  localparam logic [15:0] RST_OUT_OVERVOLT_WARN_LEVEL = 16'h384c;
  localparam logic [15:0] RST_OUT_UNDERVOLT_WARN_LEVEL = 16'h3779;
  localparam logic [15:0] RST_OUT_UNDERVOLT_FAULT_LEVEL = 16'h3770;
  localparam logic [15:0] RST_OUT_UNDERVOLT_FAULT_ACTION = 16'h0000;
  localparam logic [15:0] RST_OUT_OVERCURRENT_FAULT_ACTION = 16'h0000;
  localparam logic [15:0] RST_OUT_OVERCURRENT_WARN_LEVEL = 16'h4d00;
  localparam logic [15:0] RST_DIE_OVERTEMP_FAULT_LEVEL = 16'h5900;
  localparam logic [15:0] RST_DIE_OVERTEMP_FAULT_ACTION = 16'h00c0;
  localparam logic [15:0] RST_DIE_OVERTEMP_WARN_LEVEL = 16'h5860;
  localparam logic [15:0] RST_IN_OVERVOLT_FAULT_ACTION = 16'h00b8;
  localparam logic [15:0] RST_IN_UNDERVOLT_WARN_LEVEL = 16'hbc00;
  localparam logic [15:0] RST_TURN_ON_DELAY = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_RAMP_TIME = 16'h3c00;
  localparam logic [15:0] RST_TURN_ON_TIMEOUT = 16'h4500;
  localparam logic [15:0] RST_TURN_ON_TIMEOUT_ACTION = 16'h0000;
  localparam logic [15:0] RST_TURN_OFF_DELAY = 16'h0000;
  localparam logic [15:0] RST_TURN_OFF_RAMP_TIME = 16'h4000;
  localparam logic [15:0] RST_TURN_OFF_DECAY_WARN_TIME = 16'h0000;
  localparam logic [7:0] RST_FAULT_SUMMARY_BYTE = 8'h00;
  // ------------------------------------------------------------
  // summary byte fields and timing
  // ------------------------------------------------------------
  localparam int SUM_OFF_BIT = 6;
  localparam int SUM_OUT_OV_BIT = 5;
  localparam int SUM_OC_BIT = 4;
  localparam int SUM_IN_UV_BIT = 3;
  localparam int SUM_TEMP_BIT = 2;
  localparam int SUM_CMD_BIT = 1;
  localparam int SUM_OTHER_BIT = 0;
  localparam logic [7:0] SUM_STICKY_MASK = 8'h3f;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int TICKS_PER_MS = 1024;
  localparam int TICK_CYCLES = MS_NS / (CLK_PERIOD_NS * TICKS_PER_MS);
  localparam int NREG = 24;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_ON_WAIT, SEQ_RISE, SEQ_ON, SEQ_OFF_WAIT, SEQ_FALL, SEQ_DECAY, SEQ_FAULT
  } rlsr_seq_e;
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } rlsr_meas_s;
  typedef struct packed {
    logic out_ov_fault;
    logic out_ov_warn;
    logic out_uv_warn;
    logic out_uv_fault;
    logic oc_warn;
    logic ot_fault;
    logic ot_warn;
    logic in_uv_warn;
  } rlsr_flags_s;
endpackage
`default_nettype wire

//--- verilog/rlsr_regs.sv
`default_nettype none
module rlsr_regs
  import rlsr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic cmd_fault_out,
  input wire logic run_pin_in,
  input wire logic on_cmd_in,
  input wire rlsr_meas_s meas_in,
  input wire logic [15:0] output_discharged_level_in,
  input wire logic oc_fault_in,
  input wire logic in_ov_fault_in,
  output logic conversion_enable_out,
  output logic ramp_up_out,
  output logic ramp_down_out,
  output rlsr_flags_s flags_out,
  output logic turn_on_timeout_event_out,
  output logic decay_warn_out,
  output logic fault_event_out,
  output logic [7:0] fault_action_out,
  output logic [15:0] switching_freq_out,
  output logic [15:0] current_reading_offset_out
);

  // ------------------------------------------------------------
  // register tables
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CODE [NREG] = '{
    CODE_SWITCHING_FREQ_SETPOINT, CODE_INPUT_START_THRESHOLD, CODE_INPUT_STOP_THRESHOLD,
    CODE_CURRENT_READING_OFFSET, CODE_OUT_OVERVOLT_FAULT_LEVEL, CODE_OUT_OVERVOLT_FAULT_ACTION,
    CODE_OUT_OVERVOLT_WARN_LEVEL, CODE_OUT_UNDERVOLT_WARN_LEVEL, CODE_OUT_UNDERVOLT_FAULT_LEVEL,
    CODE_OUT_UNDERVOLT_FAULT_ACTION, CODE_OUT_OVERCURRENT_FAULT_ACTION,
    CODE_OUT_OVERCURRENT_WARN_LEVEL, CODE_DIE_OVERTEMP_FAULT_LEVEL,
    CODE_DIE_OVERTEMP_FAULT_ACTION, CODE_DIE_OVERTEMP_WARN_LEVEL, CODE_IN_OVERVOLT_FAULT_ACTION,
    CODE_IN_UNDERVOLT_WARN_LEVEL, CODE_TURN_ON_DELAY, CODE_TURN_ON_RAMP_TIME,
    CODE_TURN_ON_TIMEOUT, CODE_TURN_ON_TIMEOUT_ACTION, CODE_TURN_OFF_DELAY,
    CODE_TURN_OFF_RAMP_TIME, CODE_TURN_OFF_DECAY_WARN_TIME};
  localparam logic [15:0] REG_RESET [NREG] = '{
    RST_SWITCHING_FREQ_SETPOINT, RST_INPUT_START_THRESHOLD, RST_INPUT_STOP_THRESHOLD,
    RST_CURRENT_READING_OFFSET, RST_OUT_OVERVOLT_FAULT_LEVEL, RST_OUT_OVERVOLT_FAULT_ACTION,
    RST_OUT_OVERVOLT_WARN_LEVEL, RST_OUT_UNDERVOLT_WARN_LEVEL, RST_OUT_UNDERVOLT_FAULT_LEVEL,
    RST_OUT_UNDERVOLT_FAULT_ACTION, RST_OUT_OVERCURRENT_FAULT_ACTION,
    RST_OUT_OVERCURRENT_WARN_LEVEL, RST_DIE_OVERTEMP_FAULT_LEVEL,
    RST_DIE_OVERTEMP_FAULT_ACTION, RST_DIE_OVERTEMP_WARN_LEVEL, RST_IN_OVERVOLT_FAULT_ACTION,
    RST_IN_UNDERVOLT_WARN_LEVEL, RST_TURN_ON_DELAY, RST_TURN_ON_RAMP_TIME,
    RST_TURN_ON_TIMEOUT, RST_TURN_ON_TIMEOUT_ACTION, RST_TURN_OFF_DELAY,
    RST_TURN_OFF_RAMP_TIME, RST_TURN_OFF_DECAY_WARN_TIME};

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [7:0] summary;
    rlsr_seq_e seq;
    logic [31:0] timer;
    logic [6:0] prescale;
    logic crossed;
    logic input_ok;
    logic run_meta;
    logic run_sync;
    rlsr_flags_s flags;
    logic [3:0] fault_prev;
    logic [15:0] rd_data;
    logic rd_valid;
    logic cmd_fault;
    logic conv_en;
    logic ramp_up;
    logic ramp_down;
    logic ton_event;
    logic decay_warn;
    logic fault_event;
    logic [7:0] fault_action;
  } rlsr_state_s;

  rlsr_state_s st_r;
  rlsr_state_s st_nxt;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // map a half float onto an unsigned key that orders like the value
  function automatic logic [15:0] hf_key(input logic [15:0] h);
    hf_key = h[15] ? ~h : {1'b1, h[14:0]};
  endfunction

  // true when half float a is strictly above half float b
  function automatic logic hf_gt(input logic [15:0] a, input logic [15:0] b);
    hf_gt = hf_key(a) > hf_key(b);
  endfunction

  // half float milliseconds to timer ticks (1/1024 ms); negatives give zero
  function automatic logic [31:0] hf_ticks(input logic [15:0] h);
    logic [4:0] e;
    logic [31:0] m;
    e = h[14:10];
    m = {21'h00_0000, (e != 5'h00), h[9:0]};
    if (h[15]) begin
      hf_ticks = 32'h0000_0000;
    end else if (e == 5'h1f) begin
      hf_ticks = 32'hffff_ffff;
    end else if (e >= 5'h0f) begin
      hf_ticks = m << (e - 5'h0f);
    end else begin
      hf_ticks = m >> (5'h0f - ((e == 5'h00) ? 5'h01 : e));
    end
  endfunction

  // register index for a command code, NREG when unmapped
  function automatic logic [4:0] reg_index(input logic [7:0] code);
    reg_index = 5'(NREG);
    for (int i = 0; i < NREG; i++) begin
      if (REG_CODE[i] == code) begin
        reg_index = 5'(i);
      end
    end
  endfunction

  // current value of the register at a command code
  function automatic logic [15:0] reg_val(input rlsr_state_s s, input logic [7:0] code);
    logic [4:0] idx;
    idx = reg_index(code);
    reg_val = (idx < 5'(NREG)) ? s.regs[idx] : 16'h0000;
  endfunction

  // ------------------------------------------------------------
  // reset image
  // ------------------------------------------------------------
  // power-up contents of every register, kept constant for the async reset branch
  function automatic rlsr_state_s reset_image();
    reset_image = '0;
    for (int i = 0; i < NREG; i++) begin
      reset_image.regs[i] = REG_RESET[i];
    end
    reset_image.summary = RST_FAULT_SUMMARY_BYTE;
    reset_image.seq = SEQ_OFF;
  endfunction
  localparam rlsr_state_s ST_RST = reset_image();

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [4:0] widx;
    logic [4:0] ridx;
    logic tick;
    logic enable;
    logic above_uv;
    logic [7:0] sum_set;
    logic [7:0] sum_clr;
    logic [3:0] fault_now;
    rlsr_seq_e seq_nxt;
    widx = reg_index(cmd_code_in);
    ridx = reg_index(cmd_code_in);
    tick = 1'b0;
    enable = 1'b0;
    above_uv = 1'b0;
    sum_set = 8'h00;
    sum_clr = 8'h00;
    fault_now = 4'h0;
    seq_nxt = st_r.seq;
    st_nxt = st_r;

    // run pin synchroniser
    st_nxt.run_meta = run_pin_in;
    st_nxt.run_sync = st_r.run_meta;

    // host writes land in the working copy at once
    st_nxt.cmd_fault = 1'b0;
    if (wr_en_in) begin
      if (widx < 5'(NREG)) begin
        st_nxt.regs[widx] = wr_data_in;
        if (REG_RESET[widx][15:8] == 8'h00 && REG_CODE[widx] inside {
            CODE_OUT_OVERVOLT_FAULT_ACTION, CODE_OUT_UNDERVOLT_FAULT_ACTION,
            CODE_OUT_OVERCURRENT_FAULT_ACTION, CODE_DIE_OVERTEMP_FAULT_ACTION,
            CODE_IN_OVERVOLT_FAULT_ACTION, CODE_TURN_ON_TIMEOUT_ACTION}) begin
          st_nxt.regs[widx] = {8'h00, wr_data_in[7:0]};
        end
      end else if (cmd_code_in == CODE_FAULT_SUMMARY_BYTE) begin
        sum_clr = wr_data_in[7:0] & SUM_STICKY_MASK;
      end else begin
        st_nxt.cmd_fault = 1'b1;
      end
    end

    // register reads answer one cycle later
    st_nxt.rd_valid = rd_en_in;
    st_nxt.rd_data = 16'h0000;
    if (rd_en_in) begin
      if (ridx < 5'(NREG)) begin
        st_nxt.rd_data = st_r.regs[ridx];
      end else if (cmd_code_in == CODE_FAULT_SUMMARY_BYTE) begin
        st_nxt.rd_data = {8'h00, st_r.summary};
      end else begin
        st_nxt.cmd_fault = 1'b1;
      end
    end

    // input start/stop hysteresis
    if (!st_r.input_ok && !hf_gt(reg_val(st_r, CODE_INPUT_START_THRESHOLD), meas_in.vin)) begin
      st_nxt.input_ok = 1'b1;
    end else if (st_r.input_ok &&
                 !hf_gt(meas_in.vin, reg_val(st_r, CODE_INPUT_STOP_THRESHOLD))) begin
      st_nxt.input_ok = 1'b0;
    end
    enable = st_r.run_sync & on_cmd_in & st_r.input_ok;

    // limit comparisons
    above_uv = hf_gt(meas_in.vout, reg_val(st_r, CODE_OUT_UNDERVOLT_FAULT_LEVEL));
    st_nxt.flags.out_ov_fault =
      hf_gt(meas_in.vout, reg_val(st_r, CODE_OUT_OVERVOLT_FAULT_LEVEL));
    st_nxt.flags.out_ov_warn =
      hf_gt(meas_in.vout, reg_val(st_r, CODE_OUT_OVERVOLT_WARN_LEVEL));
    st_nxt.flags.out_uv_warn = (st_r.seq == SEQ_ON) &&
      hf_gt(reg_val(st_r, CODE_OUT_UNDERVOLT_WARN_LEVEL), meas_in.vout);
    st_nxt.flags.out_uv_fault = (st_r.seq == SEQ_ON) && !above_uv;
    st_nxt.flags.oc_warn =
      hf_gt(meas_in.iout, reg_val(st_r, CODE_OUT_OVERCURRENT_WARN_LEVEL));
    st_nxt.flags.ot_fault =
      !hf_gt(reg_val(st_r, CODE_DIE_OVERTEMP_FAULT_LEVEL), meas_in.temp);
    st_nxt.flags.ot_warn =
      hf_gt(meas_in.temp, reg_val(st_r, CODE_DIE_OVERTEMP_WARN_LEVEL));
    st_nxt.flags.in_uv_warn =
      hf_gt(reg_val(st_r, CODE_IN_UNDERVOLT_WARN_LEVEL), meas_in.vin);

    // millisecond fraction tick
    if (st_r.prescale >= 7'(TICK_CYCLES - 1)) begin
      st_nxt.prescale = 7'h00;
      tick = 1'b1;
    end else begin
      st_nxt.prescale = st_r.prescale + 7'h01;
    end
    if (tick && st_r.timer != 32'hffff_ffff) begin
      st_nxt.timer = st_r.timer + 32'h0000_0001;
    end

    // turn-on and turn-off sequencer
    st_nxt.ton_event = 1'b0;
    st_nxt.decay_warn = 1'b0;
    case (st_r.seq)
      SEQ_OFF: begin
        if (enable) begin
          seq_nxt = SEQ_ON_WAIT;
        end
      end
      SEQ_ON_WAIT: begin
        if (!enable) begin
          seq_nxt = SEQ_OFF;
        end else if (st_r.timer >= hf_ticks(reg_val(st_r, CODE_TURN_ON_DELAY))) begin
          seq_nxt = SEQ_RISE;
        end
      end
      SEQ_RISE: begin
        if (above_uv) begin
          st_nxt.crossed = 1'b1;
        end
        if (!enable) begin
          seq_nxt = SEQ_OFF_WAIT;
        end else if (!(st_r.crossed || above_uv) &&
                     st_r.timer >= hf_ticks(reg_val(st_r, CODE_TURN_ON_TIMEOUT))) begin
          st_nxt.ton_event = 1'b1;
          seq_nxt = SEQ_FAULT;
        end else if ((st_r.crossed || above_uv) &&
                     st_r.timer >= hf_ticks(reg_val(st_r, CODE_TURN_ON_RAMP_TIME))) begin
          seq_nxt = SEQ_ON;
        end
      end
      SEQ_ON: begin
        if (!enable) begin
          seq_nxt = SEQ_OFF_WAIT;
        end
      end
      SEQ_OFF_WAIT: begin
        if (st_r.timer >= hf_ticks(reg_val(st_r, CODE_TURN_OFF_DELAY))) begin
          seq_nxt = SEQ_FALL;
        end
      end
      SEQ_FALL: begin
        if (st_r.timer >= hf_ticks(reg_val(st_r, CODE_TURN_OFF_RAMP_TIME))) begin
          seq_nxt = SEQ_DECAY;
        end
      end
      SEQ_DECAY: begin
        if (!hf_gt(meas_in.vout, output_discharged_level_in)) begin
          seq_nxt = SEQ_OFF;
        end else if (st_r.timer >=
                     hf_ticks(reg_val(st_r, CODE_TURN_OFF_DECAY_WARN_TIME))) begin
          st_nxt.decay_warn = 1'b1;
          seq_nxt = SEQ_OFF;
        end
      end
      SEQ_FAULT: begin
        if (!enable) begin
          seq_nxt = SEQ_OFF;
        end
      end
      default: begin
        seq_nxt = SEQ_OFF;
      end
    endcase
    // losing the input supply stops conversion at once
    if (!st_r.input_ok && st_r.seq != SEQ_FAULT) begin
      seq_nxt = SEQ_OFF;
    end
    if (seq_nxt != st_r.seq) begin
      st_nxt.timer = 32'h0000_0000;
      st_nxt.crossed = 1'b0;
    end
    st_nxt.seq = seq_nxt;
    st_nxt.conv_en = seq_nxt inside {SEQ_RISE, SEQ_ON, SEQ_OFF_WAIT, SEQ_FALL};
    st_nxt.ramp_up = (seq_nxt == SEQ_RISE);
    st_nxt.ramp_down = (seq_nxt == SEQ_FALL);

    // fault events pick up their action byte, highest priority first
    fault_now = {st_nxt.flags.out_ov_fault, in_ov_fault_in, st_nxt.flags.ot_fault,
                 oc_fault_in};
    st_nxt.fault_prev = fault_now;
    st_nxt.fault_event = 1'b1;
    if (fault_now[3] && !st_r.fault_prev[3]) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_OUT_OVERVOLT_FAULT_ACTION));
    end else if (fault_now[2] && !st_r.fault_prev[2]) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_IN_OVERVOLT_FAULT_ACTION));
    end else if (fault_now[1] && !st_r.fault_prev[1]) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_DIE_OVERTEMP_FAULT_ACTION));
    end else if (st_nxt.flags.out_uv_fault && !st_r.flags.out_uv_fault) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_OUT_UNDERVOLT_FAULT_ACTION));
    end else if (st_nxt.ton_event) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_TURN_ON_TIMEOUT_ACTION));
    end else if (fault_now[0] && !st_r.fault_prev[0]) begin
      st_nxt.fault_action = 8'(reg_val(st_r, CODE_OUT_OVERCURRENT_FAULT_ACTION));
    end else begin
      st_nxt.fault_event = 1'b0;
    end

    // summary byte: sticky bits, a new event wins over a clear
    sum_set[SUM_OUT_OV_BIT] = st_nxt.flags.out_ov_fault;
    sum_set[SUM_OC_BIT] = oc_fault_in | st_nxt.flags.oc_warn;
    sum_set[SUM_IN_UV_BIT] = st_nxt.flags.in_uv_warn;
    sum_set[SUM_TEMP_BIT] = st_nxt.flags.ot_fault | st_nxt.flags.ot_warn;
    sum_set[SUM_CMD_BIT] = st_nxt.cmd_fault;
    sum_set[SUM_OTHER_BIT] = st_nxt.ton_event | st_nxt.decay_warn |
                             st_nxt.flags.out_uv_fault | in_ov_fault_in;
    st_nxt.summary = ((st_r.summary & ~sum_clr) | sum_set) & SUM_STICKY_MASK;
    st_nxt.summary[SUM_OFF_BIT] = !st_nxt.conv_en;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rd_data_out = st_r.rd_data;
  assign rd_valid_out = st_r.rd_valid;
  assign cmd_fault_out = st_r.cmd_fault;
  assign conversion_enable_out = st_r.conv_en;
  assign ramp_up_out = st_r.ramp_up;
  assign ramp_down_out = st_r.ramp_down;
  assign flags_out = st_r.flags;
  assign turn_on_timeout_event_out = st_r.ton_event;
  assign decay_warn_out = st_r.decay_warn;
  assign fault_event_out = st_r.fault_event;
  assign fault_action_out = st_r.fault_action;
  // frequency set point drives the oscillator directly
  assign switching_freq_out = st_r.regs[0];
  assign current_reading_offset_out = st_r.regs[3];

endmodule
`default_nettype wire

//--- verif/rlsr_regs_properties.sv
`default_nettype none
module rlsr_regs_properties
  import rlsr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic cmd_fault_out,
  input wire logic ramp_up_out,
  input wire logic ramp_down_out,
  input wire logic turn_on_timeout_event_out,
  input wire logic [15:0] switching_freq_out,
  input wire logic [15:0] current_reading_offset_out
);
  // --------------------
  // port timing checks
  // --------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_rd_pulse; rd_en_in |=> rd_valid_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
  property p_rd_idle; !rd_en_in |=> !rd_valid_out && rd_data_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_freq_wr; wr_en_in && cmd_code_in == 8'h33 |=> switching_freq_out == $past(wr_data_in);
  endproperty
  a_freq_wr: assert property (p_freq_wr) else $error("frequency write lost");
  property p_ofs_wr;
    wr_en_in && cmd_code_in == 8'h39 |=> current_reading_offset_out == $past(wr_data_in);
  endproperty
  a_ofs_wr: assert property (p_ofs_wr) else $error("offset write lost");
  property p_freq_rd;
    rd_en_in && !wr_en_in && cmd_code_in == 8'h33 |=> rd_data_out == switching_freq_out;
  endproperty
  a_freq_rd: assert property (p_freq_rd) else $error("frequency readback wrong");
  property p_byte_hi; rd_en_in && cmd_code_in == 8'h41 |=> rd_data_out[15:8] == 8'h00; endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("byte register upper bits set");
  property p_bad_code; (wr_en_in || rd_en_in) && cmd_code_in == 8'h00 |=> cmd_fault_out; endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not flagged");
  property p_good_code; (wr_en_in || rd_en_in) && cmd_code_in == 8'h33 |=> !cmd_fault_out;
  endproperty
  a_good_code: assert property (p_good_code) else $error("good code flagged");
  property p_ramps; !(ramp_up_out && ramp_down_out); endproperty
  a_ramps: assert property (p_ramps) else $error("both ramps active");
  property p_ton_pulse; turn_on_timeout_event_out |=> !turn_on_timeout_event_out; endproperty
  a_ton_pulse: assert property (p_ton_pulse) else $error("timeout event too long");
endmodule
bind rlsr_regs rlsr_regs_properties u_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .cmd_code_in(cmd_code_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .cmd_fault_out(cmd_fault_out), .ramp_up_out(ramp_up_out), .ramp_down_out(ramp_down_out),
  .turn_on_timeout_event_out(turn_on_timeout_event_out),
  .switching_freq_out(switching_freq_out),
  .current_reading_offset_out(current_reading_offset_out));
`default_nettype wire

//--- verif/rlsr_host.sv
`default_nettype none
module rlsr_host (
  input wire logic clk_sys_in,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic [7:0] cmd_code_out,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [15:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    cmd_code_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wr_data_out = 16'h0000;
  end
  // word write; idle lines show the inverse so stale values never look valid
  task automatic write(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_in);
    cmd_code_out <= c;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_out <= 1'b0;
    cmd_code_out <= ~c;
    wr_data_out <= ~d;
  endtask
  // word read; answer taken one edge after the strobe is seen
  task automatic read(input logic [7:0] c, output logic [15:0] d, output logic ok);
    @(posedge clk_sys_in);
    cmd_code_out <= c;
    rd_en_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_out <= 1'b0;
    cmd_code_out <= ~c;
    @(posedge clk_sys_in);
    d = rd_data_in;
    ok = rd_valid_in;
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
`default_nettype none
module testbench
  import rlsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic run_pin = 1'b0;
  logic on_cmd = 1'b0;
  logic saw = 1'b0;
  logic [15:0] dlvl = 16'h0000;
  rlsr_meas_s meas = '0;
  logic [7:0] cmd, fact, act, flg;
  logic wr, rd, rv, ok, conv, ton, ramp_up;
  logic ocf = 1'b0, inov = 1'b0, fev, dw;
  logic [15:0] wd, rdat, got;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] codes [24] = '{8'h33, 8'h35, 8'h36, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
    8'h45, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h56, 8'h58, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
    8'h65, 8'h66};
  logic [15:0] dflt [24] = '{16'h63d0, 16'h3d9a, 16'h3d66, 16'h2e66, 16'h3866, 16'h00b8,
    16'h384c, 16'h3779, 16'h3770, 16'h0000, 16'h0000, 16'h4d00, 16'h5900, 16'h00c0, 16'h5860,
    16'h00b8, 16'hbc00, 16'h0000, 16'h3c00, 16'h4500, 16'h0000, 16'h0000, 16'h4000, 16'h0000};
  // clock and parts
  always #4 clk_sys_in = ~clk_sys_in;
  rlsr_regs uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cmd_code_in(cmd),
    .wr_en_in(wr), .wr_data_in(wd), .rd_en_in(rd), .rd_data_out(rdat), .rd_valid_out(rv),
    .cmd_fault_out(), .run_pin_in(run_pin), .on_cmd_in(on_cmd), .meas_in(meas),
    .output_discharged_level_in(dlvl), .oc_fault_in(ocf), .in_ov_fault_in(inov),
    .conversion_enable_out(conv), .ramp_up_out(ramp_up), .ramp_down_out(), .flags_out(flg),
    .turn_on_timeout_event_out(ton), .decay_warn_out(dw), .fault_event_out(fev),
    .fault_action_out(fact), .switching_freq_out(), .current_reading_offset_out());
  rlsr_host host (.clk_sys_in(clk_sys_in), .rd_data_in(rdat), .rd_valid_in(rv),
    .cmd_code_out(cmd), .wr_en_out(wr), .rd_en_out(rd), .wr_data_out(wd));
  // byte registers keep only the low byte
  function automatic logic [15:0] exp_word(logic [7:0] c, logic [15:0] d);
    return (c inside {8'h41, 8'h45, 8'h47, 8'h50, 8'h56, 8'h63}) ? {8'h00, d[7:0]} : d;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    host.read(c, got, ok);
    chk(ok === 1'b1 ? got : ~e, e);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(61501));
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rchk(8'h78, 16'h0040);
    foreach (codes[i]) rchk(codes[i], dflt[i]);
    rchk(8'h00, 16'h0000);
    rchk(8'h78, 16'h0042);
    host.write(8'h78, 16'h0002);
    rchk(8'h78, 16'h0040);
    foreach (codes[i]) begin
      got = 16'($urandom);
      host.write(codes[i], got);
      rchk(codes[i], exp_word(codes[i], got));
    end
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rchk(8'h33, 16'h63d0);
    act = 8'($urandom);
    host.write(8'h61, 16'h1400);
    host.write(8'h62, 16'h2000);
    host.write(8'h63, {8'h00, act});
    meas.vin <= 16'h3c00;
    run_pin <= 1'b1;
    on_cmd <= 1'b1;
    dlvl <= 16'h8000 | 16'($urandom); // negative, so output never decays below it
    repeat (300) @(posedge clk_sys_in);
    chk({15'h0, conv}, 16'h0000);
    meas.vin <= 16'h3e00;
    for (int n = 0; n < 3000 && ton !== 1'b1; n++) begin
      @(posedge clk_sys_in);
      saw = saw | conv;
    end
    chk({14'h0, saw, ton}, 16'h0003);
    @(posedge clk_sys_in);
    chk({8'h00, fact}, {8'h00, act});
    on_cmd <= 1'b0;
    meas.vout <= 16'h3800;
    repeat (6) @(posedge clk_sys_in);
    on_cmd <= 1'b1;
    repeat (600) @(posedge clk_sys_in);
    chk({14'h0, conv, ramp_up}, 16'h0002);
    host.write(8'h65, 16'h1400);
    on_cmd <= 1'b0;
    for (int n = 0; n < 300 && dw !== 1'b1; n++) @(posedge clk_sys_in);
    chk({15'h0, dw}, 16'h0001);
    on_cmd <= 1'b1;
    repeat (300) @(posedge clk_sys_in);
    chk({15'h0, conv}, 16'h0001);
    meas.vin <= 16'h3c00;
    repeat (6) @(posedge clk_sys_in);
    chk({15'h0, conv}, 16'h0000);
    host.write(8'h47, {8'h00, ~act});
    inov <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk({7'h0, fev, fact}, 16'h01b8);
    ocf <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk({7'h0, fev, fact}, {8'h01, ~act});
    meas.temp <= 16'h5900;
    repeat (2) @(posedge clk_sys_in);
    chk({flg, fact}, 16'h06c0);
    give_verdict();
  end
  // watchdog against a hung run
  initial begin
    #400000;
    n_errors++;
    $display("unexpected at %0t: run too long", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
